//--- reset_seq_pkg.sv
// package: reset sequencer types, encodings and timing constants
package reset_seq_pkg;

  // --------------------------------------------------------------------
  // sequence kinds
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_DESTRUCTIVE_BIST   = 3'h0,
    SEQ_DESTRUCTIVE_NOBIST = 3'h1,
    SEQ_EXTERNAL_LONG      = 3'h2,
    SEQ_FUNCTIONAL_LONG    = 3'h3,
    SEQ_FUNCTIONAL_SHORT   = 3'h4
  } seq_kind_type;

  // --------------------------------------------------------------------
  // sequencer states, one-hot
  // --------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_POR_HOLD = 6'h01,
    ST_PHASE    = 6'h02,
    ST_FINAL    = 6'h04,
    ST_EXTEND   = 6'h08,
    ST_BOOT     = 6'h10,
    ST_RUN      = 6'h20
  } seq_state_type;

  // functional reset request carried from the reset sources
  typedef struct packed {
    logic valid;
    logic long_seq;
    logic pin_drive;
  } func_req_type;

  // reset pin as open-drain pad signals
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_type;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_MHZ          = 50;
  localparam int DR_US            = 50;
  localparam int FRL_US           = 50;
  localparam int FRS_MIN_US       = 2;
  localparam int FRS_MAX_US       = 7;
  localparam int DRB_MS           = 25;
  localparam int DR_CYCLES        = DR_US * CLK_MHZ;
  localparam int FRL_CYCLES       = FRL_US * CLK_MHZ;
  localparam int FRS_CYCLES       = FRS_MIN_US * CLK_MHZ;
  localparam int FRS_MAX_CYCLES   = FRS_MAX_US * CLK_MHZ;
  localparam int DRB_CYCLES       = DRB_MS * 1000 * CLK_MHZ;
  localparam int FINAL_CYCLES     = 16;
  localparam int CNT_W            = 24;
  localparam logic [1:0] PIN_RESET_VAL = 2'h0;

endpackage : reset_seq_pkg

//--- reset_seq_ctrl.sv
// reset sequencer with open-drain reset pin control
// Operation
// - start internal reset sequence when power-on reset input is released
// - reset pin is bidirectional; device or external generator pulls it low
// - device only drives pin low or releases it, never high
// - device releases pin at end of internal sequence
// - pin held low externally past final phase extends the sequence
// - functional sequences drive pin only if source pin-drive enable set
// - five sequences: destructive with/without BIST, external, functional long/short
// - application starts only after boot code completes and jumps
// - short functional sequence lasts between 2 and 7 microseconds
module reset_seq_ctrl #(
  parameter int DRB_CYCLES   = reset_seq_pkg::DRB_CYCLES,
  parameter int DR_CYCLES    = reset_seq_pkg::DR_CYCLES,
  parameter int FRL_CYCLES   = reset_seq_pkg::FRL_CYCLES,
  parameter int FRS_CYCLES   = reset_seq_pkg::FRS_CYCLES,
  parameter int FINAL_CYCLES = reset_seq_pkg::FINAL_CYCLES
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       nrst_i,
  input  wire logic                       clk_en_i,
  input  wire logic                       external_power_on_reset_n_i,
  input  wire logic                       bist_enable_i,
  input  wire logic                       destructive_req_i,
  input  wire logic                       external_req_i,
  input  wire reset_seq_pkg::func_req_type func_req_i,
  input  wire logic                       boot_done_i,
  input  wire logic                       reset_pin_i,
  output logic                            reset_pin_o,
  output logic                            reset_pin_oe_o,
  output logic                            in_reset_o,
  output logic                            app_run_o,
  output reset_seq_pkg::seq_kind_type     seq_kind_o
);

  // --------------------------------------------------------------------
  // pin synchroniser
  // --------------------------------------------------------------------
  logic pin_meta;
  logic pin_sync;

  // two flops, only the second is used
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else if (clk_en_i) begin
      pin_meta <= reset_pin_i;
      pin_sync <= pin_meta;
    end
  end

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  reset_seq_pkg::seq_state_type state;
  reset_seq_pkg::seq_state_type next_state;
  reset_seq_pkg::seq_kind_type  kind;
  reset_seq_pkg::seq_kind_type  next_kind;
  logic [reset_seq_pkg::CNT_W-1:0] cnt;
  logic [reset_seq_pkg::CNT_W-1:0] next_cnt;
  logic drive;
  logic next_drive;
  logic in_reset;
  logic next_in_reset;
  logic app_run;
  logic next_app_run;

  // phase length for each sequence kind
  function automatic logic [reset_seq_pkg::CNT_W-1:0] phase_len(
    input reset_seq_pkg::seq_kind_type k
  );
    case (k)
      reset_seq_pkg::SEQ_DESTRUCTIVE_BIST:   phase_len = reset_seq_pkg::CNT_W'(DRB_CYCLES);
      reset_seq_pkg::SEQ_DESTRUCTIVE_NOBIST: phase_len = reset_seq_pkg::CNT_W'(DR_CYCLES);
      reset_seq_pkg::SEQ_EXTERNAL_LONG:      phase_len = reset_seq_pkg::CNT_W'(DRB_CYCLES);
      reset_seq_pkg::SEQ_FUNCTIONAL_LONG:    phase_len = reset_seq_pkg::CNT_W'(FRL_CYCLES);
      default:                               phase_len = reset_seq_pkg::CNT_W'(FRS_CYCLES);
    endcase
  endfunction

  // next-state logic
  always_comb begin
    next_state    = state;
    next_kind     = kind;
    next_cnt      = cnt;
    next_drive    = drive;
    next_in_reset = in_reset;
    next_app_run  = app_run;
    case (state)
      reset_seq_pkg::ST_POR_HOLD: begin
        next_drive    = 1'b1;
        next_in_reset = 1'b1;
        if (external_power_on_reset_n_i) begin
          next_kind  = bist_enable_i ? reset_seq_pkg::SEQ_DESTRUCTIVE_BIST
                                     : reset_seq_pkg::SEQ_DESTRUCTIVE_NOBIST;
          next_cnt   = '0;
          next_state = reset_seq_pkg::ST_PHASE;
        end
      end
      reset_seq_pkg::ST_PHASE: begin
        next_cnt = cnt + 1'b1;
        if (cnt + reset_seq_pkg::CNT_W'(FINAL_CYCLES) + 1'b1 >= phase_len(kind)) begin
          next_cnt   = '0;
          next_state = reset_seq_pkg::ST_FINAL;
        end
      end
      reset_seq_pkg::ST_FINAL: begin
        next_cnt = cnt + 1'b1;
        if (cnt == reset_seq_pkg::CNT_W'(FINAL_CYCLES - 1)) begin
          next_drive = 1'b0;
          next_state = reset_seq_pkg::ST_EXTEND;
        end
      end
      reset_seq_pkg::ST_EXTEND: begin
        next_drive = 1'b0;
        if (pin_sync) begin
          next_in_reset = 1'b0;
          next_state    = reset_seq_pkg::ST_BOOT;
        end
      end
      reset_seq_pkg::ST_BOOT: begin
        if (boot_done_i) begin
          next_app_run = 1'b1;
          next_state   = reset_seq_pkg::ST_RUN;
        end
      end
      reset_seq_pkg::ST_RUN: begin
        // new reset requests, destructive first
        if (destructive_req_i || external_req_i || func_req_i.valid) begin
          next_app_run  = 1'b0;
          next_in_reset = 1'b1;
          next_cnt      = '0;
          next_state    = reset_seq_pkg::ST_PHASE;
          if (destructive_req_i) begin
            next_drive = 1'b1;
            next_kind  = bist_enable_i ? reset_seq_pkg::SEQ_DESTRUCTIVE_BIST
                                       : reset_seq_pkg::SEQ_DESTRUCTIVE_NOBIST;
          end else if (external_req_i) begin
            next_drive = 1'b1;
            next_kind  = reset_seq_pkg::SEQ_EXTERNAL_LONG;
          end else begin
            next_drive = func_req_i.pin_drive;
            next_kind  = func_req_i.long_seq ? reset_seq_pkg::SEQ_FUNCTIONAL_LONG
                                             : reset_seq_pkg::SEQ_FUNCTIONAL_SHORT;
          end
        end else if (!pin_sync) begin
          // external generator pulls pin low: external long sequence
          next_app_run  = 1'b0;
          next_in_reset = 1'b1;
          next_cnt      = '0;
          next_drive    = 1'b1;
          next_kind     = reset_seq_pkg::SEQ_EXTERNAL_LONG;
          next_state    = reset_seq_pkg::ST_PHASE;
        end
      end
      default: begin
        next_state = reset_seq_pkg::ST_POR_HOLD;
      end
    endcase
    if (!external_power_on_reset_n_i) begin
      next_state    = reset_seq_pkg::ST_POR_HOLD;
      next_drive    = 1'b1;
      next_in_reset = 1'b1;
      next_app_run  = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state    <= reset_seq_pkg::ST_POR_HOLD;
      kind     <= reset_seq_pkg::SEQ_DESTRUCTIVE_NOBIST;
      cnt      <= '0;
      drive    <= 1'b1;
      in_reset <= 1'b1;
      app_run  <= 1'b0;
    end else if (clk_en_i) begin
      state    <= next_state;
      kind     <= next_kind;
      cnt      <= next_cnt;
      drive    <= next_drive;
      in_reset <= next_in_reset;
      app_run  <= next_app_run;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  reset_seq_pkg::pin_drive_type pin;
  reset_seq_pkg::pin_drive_type next_pin;

  // pin level is always low; only the enable moves
  always_comb begin
    next_pin.out = 1'b0;
    next_pin.oe  = next_drive;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin        <= '{out: 1'b0, oe: 1'b1};
      seq_kind_o <= reset_seq_pkg::SEQ_DESTRUCTIVE_NOBIST;
    end else if (clk_en_i) begin
      pin        <= next_pin;
      seq_kind_o <= next_kind;
    end
  end

  assign reset_pin_o    = pin.out;
  assign reset_pin_oe_o = pin.oe;
  assign in_reset_o     = in_reset;
  assign app_run_o      = app_run;

endmodule // reset_seq_ctrl

//--- reset_seq_ctrl_assertions.sv
// checker: reset sequencer port assertions
module reset_seq_chk #(
  parameter int FRS_CYCLES   = 40,
  parameter int FINAL_CYCLES = 4
) (
  input wire logic                        core_clk_i,
  input wire logic                        nrst_i,
  input wire logic                        external_power_on_reset_n_i,
  input wire logic                        bist_enable_i,
  input wire logic                        destructive_req_i,
  input wire reset_seq_pkg::func_req_type func_req_i,
  input wire logic                        boot_done_i,
  input wire logic                        reset_pin_i,
  input wire logic                        reset_pin_o,
  input wire logic                        reset_pin_oe_o,
  input wire logic                        in_reset_o,
  input wire logic                        app_run_o,
  input wire reset_seq_pkg::seq_kind_type seq_kind_o
);
  localparam int FRS_LO   = FRS_CYCLES - 2;
  localparam int FRS_SPAN = FINAL_CYCLES + 4;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_low_only; reset_pin_o == 1'b0; endproperty
  a_low_only: assert property (p_low_only) else $error("pin driven high");
  property p_por; !external_power_on_reset_n_i |=> in_reset_o && reset_pin_oe_o && !app_run_o;
  endproperty
  a_por: assert property (p_por) else $error("por low not held");
  property p_oe_in_reset; reset_pin_oe_o |-> in_reset_o; endproperty
  a_oe_in_reset: assert property (p_oe_in_reset) else $error("pin pulled outside reset");
  property p_extend; $fell(in_reset_o) |-> $past(reset_pin_i, 3); endproperty
  a_extend: assert property (p_extend) else $error("ended while pin low");
  property p_func_drive;
    $rose(in_reset_o) && seq_kind_o inside {reset_seq_pkg::SEQ_FUNCTIONAL_LONG,
      reset_seq_pkg::SEQ_FUNCTIONAL_SHORT} |-> reset_pin_oe_o == $past(func_req_i.pin_drive);
  endproperty
  a_func_drive: assert property (p_func_drive) else $error("pin drive enable ignored");
  property p_destr_kind;
    $rose(in_reset_o) && $past(destructive_req_i) |-> seq_kind_o == {2'h0, !$past(bist_enable_i)};
  endproperty
  a_destr_kind: assert property (p_destr_kind) else $error("wrong destructive kind");
  property p_short;
    $rose(reset_pin_oe_o) && seq_kind_o == reset_seq_pkg::SEQ_FUNCTIONAL_SHORT
      |-> ##FRS_LO reset_pin_oe_o ##[1:FRS_SPAN] !reset_pin_oe_o;
  endproperty
  a_short: assert property (p_short) else $error("short sequence length");
  property p_run; $rose(app_run_o) |-> $past(boot_done_i) && !in_reset_o; endproperty
  a_run: assert property (p_run) else $error("run before boot done");
endmodule // reset_seq_chk
bind reset_seq_ctrl reset_seq_chk #(.FRS_CYCLES(FRS_CYCLES), .FINAL_CYCLES(FINAL_CYCLES)) u_chk (
  .core_clk_i, .nrst_i, .external_power_on_reset_n_i, .bist_enable_i, .destructive_req_i,
  .func_req_i, .boot_done_i, .reset_pin_i, .reset_pin_o, .reset_pin_oe_o, .in_reset_o,
  .app_run_o, .seq_kind_o);

//--- board_model.sv
// board model: pulled-up reset pin, reset generator, supply-gated power-on reset
module board_model (
  input  wire logic core_clk_i,
  input  wire logic supply_ok_i,
  input  wire logic gen_hold_i,
  input  wire logic pin_oe_i,
  output logic      por_n_o,
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // power-on reset released only once supplies are stable
  always_ff @(posedge core_clk_i) por_n_o <= supply_ok_i;
  // either party pulls low, pull-up gives the high level
  assign pin_o = !(gen_hold_i || pin_oe_i);
endmodule // board_model

//--- testbench.sv
// testbench: reset sequencer on the board model, with drive/reset span and value checks
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FIN = 4;
  localparam int LEN[6] = '{200, 60, 200, 60, 40, 200};
  logic core_clk_i = 1'b0, nrst_i = 1'b0, supply_ok = 1'b0, hold = 1'b0, bist = 1'b0;
  logic destr = 1'b0, ext = 1'b0, boot = 1'b0, por_n, pin, pin_o, oe, in_reset, app_run;
  reset_seq_pkg::func_req_type freq = '0;
  reset_seq_pkg::seq_kind_type kind;
  int num_errors = 0, comparisons = 0;
  // clock
  always #10 core_clk_i = ~core_clk_i;
  board_model u_board (.core_clk_i(core_clk_i), .supply_ok_i(supply_ok), .gen_hold_i(hold),
    .pin_oe_i(oe), .por_n_o(por_n), .pin_o(pin));
  reset_seq_ctrl #(.DRB_CYCLES(200), .DR_CYCLES(60), .FRL_CYCLES(60), .FRS_CYCLES(40),
    .FINAL_CYCLES(FIN)) u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_en_i(1'b1),
    .external_power_on_reset_n_i(por_n), .bist_enable_i(bist), .destructive_req_i(destr),
    .external_req_i(ext), .func_req_i(freq), .boot_done_i(boot), .reset_pin_i(pin),
    .reset_pin_o(pin_o), .reset_pin_oe_o(oe), .in_reset_o(in_reset), .app_run_o(app_run),
    .seq_kind_o(kind));
  task automatic check_val(input logic [2:0] got, input logic [2:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic check_span(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("[ERR] %0t %s %0d not in %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // count drive and reset spans, then boot into run
  task automatic finish_seq(input int lo, hi, oe_lo, oe_hi, hold_n);
    int n_oe;
    int n_rst;
    n_oe = 0;
    n_rst = 0;
    while (in_reset === 1'b1 && n_rst < 3000) begin
      // an unknown drive enable blows the count so the span check trips
      n_oe += (oe === 1'b1) ? 1 : ((oe === 1'b0) ? 0 : 10000);
      n_rst++;
      @(posedge core_clk_i);
      hold <= (n_rst < hold_n);
    end
    check_span(n_oe, oe_lo, oe_hi, "drive span");
    check_span(n_rst, lo, hi, "reset span");
    repeat (3) @(posedge core_clk_i);
    check_val(app_run, 1'b0, "early run");
    boot <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    check_val(app_run, 1'b1, "run");
  endtask
  // kind 5 is the generator pulling the pin low with no request
  task automatic run_seq(input int k, input logic drive, input int hold_n);
    int mx;
    logic drv;
    mx = (hold_n > LEN[k]) ? hold_n : LEN[k];
    drv = (k < 3 || k == 5 || drive);
    boot <= 1'b0;
    bist <= (k == 0);
    destr <= (k < 2);
    ext <= (k == 2);
    freq <= '{k == 3 || k == 4, k == 3, drive};
    hold <= (hold_n > 0);
    @(posedge core_clk_i);
    destr <= 1'b0;
    ext <= 1'b0;
    freq <= '0;
    for (int i = 0; i < 6 && in_reset !== 1'b1; i++) @(posedge core_clk_i);
    check_val(kind, 3'(k == 5 ? 2 : k), "kind");
    check_val(oe, drv, "drive");
    check_val(pin_o, 1'b0, "pin level");
    finish_seq(mx - 1, mx + FIN + 8, drv ? LEN[k] - 1 : 0, drv ? LEN[k] + FIN + 2 : 0, hold_n);
    $display("sequence %0d drive %0b hold %0d done", k, drive, hold_n);
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h86B5));
    repeat (12) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    check_val(in_reset, 1'b1, "por hold");
    supply_ok <= 1'b1;
    finish_seq(1, 400, 1, 400, 0);
    $display("power-on sequence done");
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 6; k++) begin
        run_seq(k, r[0], k == 5 ? 30 : $urandom_range(LEN[k] + 30));
      end
    end
    // supplies lost while running: back to power-on hold, then a fresh sequence
    boot <= 1'b0;
    supply_ok <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    check_val(in_reset, 1'b1, "por reentry");
    check_val(oe, 1'b1, "por reentry drive");
    check_val(app_run, 1'b0, "por reentry run");
    supply_ok <= 1'b1;
    finish_seq(1, 400, 1, 400, 0);
    $display("power-on reentry done");
    report_and_stop();
  end
  // watchdog
  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end
endmodule // testbench
